// ---- verilog/uwfr_pkg.sv ----
// Package: register map, fields, states and carriers of the receive sequencer
package uwfr_pkg;

   // Register indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_SYS_CFG      = 8'h04;
   localparam logic [7:0] IDX_FWT_PERIOD   = 8'h0C;
   localparam logic [7:0] IDX_EVT_STATUS   = 8'h0F;
   localparam logic [7:0] IDX_RX_TSTAMP    = 8'h15;
   localparam logic [7:0] IDX_DUTY_CFG     = 8'h1D;
   localparam logic [7:0] IDX_USER_DELIM   = 8'h21;
   // Registers with no printed index
   localparam logic [7:0] IDX_CHUNK_SIZE   = 8'h30;
   localparam logic [7:0] IDX_DELIM_TO     = 8'h31;
   localparam logic [7:0] IDX_PRE_TO       = 8'h32;
   localparam logic [7:0] IDX_ANT_DELAY    = 8'h33;
   localparam logic [7:0] IDX_PWR_CLK      = 8'h34;
   localparam logic [7:0] IDX_EVT_MASK     = 8'h35;
   localparam logic [7:0] IDX_CONTROL      = 8'h36;
   localparam logic [7:0] IDX_FP_CORR      = 8'h37;

   // System configuration fields
   localparam int CFG_LONG_DELIM   = 22;
   localparam int CFG_FWT_EN       = 28;
   localparam int CFG_AUTO_REEN    = 29;
   localparam int CFG_USER_DELIM   = 17;
   localparam int CFG_FILTER_EN    = 0;
   // Control fields (write-one commands)
   localparam int CTL_RX_ENABLE    = 8;
   localparam int CTL_RX_OFF       = 6;
   // Power/clock control: receiver-only soft reset bit
   localparam int PWR_RX_RESET     = 28;

   // Event status bit positions
   localparam int EV_FRAME_READY   = 13;
   localparam int EV_CHECK_GOOD    = 14;
   localparam int EV_HDR_ERR       = 12;
   localparam int EV_RS_ERR        = 16;
   localparam int EV_FWT           = 17;
   localparam int EV_PRE_TO        = 21;
   localparam int EV_DELIM_TO      = 26;
   localparam int EV_DELIM_DET     = 10;
   localparam int EV_PRE_DET       = 8;

   // Reset values
   localparam logic [31:0] RST_DELIM_TO   = 32'h0000_1041; // 4161 symbols
   localparam logic [31:0] RST_CHUNK      = 32'h0000_0008;
   localparam logic [31:0] RST_ZERO       = 32'h0000_0000;
   localparam logic [31:0] RD_NONE        = 32'h0000_0000;

   // Delimiter lengths in symbols
   localparam logic [6:0] DELIM_LONG   = 7'h40;
   localparam logic [6:0] DELIM_SHORT  = 7'h08;
   localparam logic [6:0] ONE7         = 7'h01;
   localparam logic [31:0] ONE32       = 32'h0000_0001;
   localparam logic [3:0] ONE4         = 4'h1;
   localparam logic [12:0] ONE13       = 13'h0001;

   // Symbol period: about 1 us at the reference rate
   localparam int SYM_NS        = 1024;
   localparam int CLK_NS        = 8;
   localparam logic [7:0] SYM_CYC = 8'(SYM_NS / CLK_NS - 1);

   // Accumulator saturation threshold for early stop
   localparam logic [12:0] ACC_FULL = 13'h1000;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_HUNT   = 3'b001,
      ST_ACCUM  = 3'b011,
      ST_HDR    = 3'b010,
      ST_DATA   = 3'b110
   } uwfr_state_t;

   // Host register bus request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } uwfr_bus_t;

   // Radio-side demodulator indications, same clock
   typedef struct packed {
      logic        pre_hit;     // Correlation chunk matched preamble
      logic        delim_hit;   // Delimiter pattern found
      logic [6:0]  delim_len;   // Delimiter length observed
      logic [31:0] delim_code;  // Delimiter code observed
      logic        acc_grow;    // Accumulator increment
      logic        hdr_done;    // Header decoded by the Viterbi path
      logic        hdr_ok;      // Header parity good
      logic        hdr_fast;    // Header indicates 6.8 Mbps
      logic        oct_valid;   // Corrected octet available
      logic [7:0]  oct;
      logic        rs_fail;     // Reed-Solomon uncorrectable
      logic        frame_end;   // Last octet
      logic        crc_ok;      // Checker matches the check sequence
      logic [31:0] coarse_ts;   // Coarse time of marker symbol
   } uwfr_radio_t;

   // Radio-side controls
   typedef struct packed {
      logic       listen;       // Receiver front end powered
      logic       bpm_mode;     // BPM/BPSK demodulation active
      logic       fast_rate;    // Data at 6.8 Mbps
      logic       long_delim;   // Hunt 64-symbol delimiter
      logic [6:0] chunk;        // Correlation chunk size
      logic       accumulate;   // Preamble accumulation on
      logic       filt_valid;   // Octet to frame filter
      logic [7:0] filt_oct;
   } uwfr_ctrl_t;

endpackage : uwfr_pkg

// ---- verilog/uwfr_sequencer.sv ----
// Receive sequencer: preamble hunt, delimiter, header, data, status, stamp
//
// Functional notes
// - Start on request or re-enable, hunt continuously
// - Optional preamble timeout aborts, raises flag
// - Correlate in chunks; chunk 64 misses 64-preamble
// - Duty-cycled listening saves power while hunting
// - Accumulate preamble; early stop keeps delimiter hunt
// - Delimiter marks header, stamp, BPM demodulation
// - Delimiter timeout from detection, default 4161
// - Long delimiter bit selects 64 else 8
// - Host-programmed delimiter replaces standard one
// - Header at 850k; switch to 6.8M after
// - Viterbi, Reed-Solomon, CRC check every octet
// - Octets fed to filter when enabled
// - Success sets frame-ready and check-good flags
// - Distinct flags for each failure kind except bad CRC, shown as frame-ready without check-good
// - Stamp is coarse minus antenna delay plus correction
// - Frame wait timeout only when enabled
`timescale 1ns/1ps
module uwfr_sequencer (
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   input  wire uwfr_pkg::uwfr_bus_t  bus,
   output logic [31:0]               rd_data,
   input  wire uwfr_pkg::uwfr_radio_t radio,
   output uwfr_pkg::uwfr_ctrl_t      ctrl,
   output logic                      irq
);

   // All checks below sample on the one clock, quiet in reset
   default clocking cb_ref @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   typedef struct packed {
      uwfr_pkg::uwfr_state_t st;
      logic [31:0] cfg;
      logic [31:0] fwt_period;
      logic [31:0] status;
      logic [31:0] mask;
      logic [31:0] tstamp;
      logic [31:0] duty;
      logic [31:0] user_delim;
      logic [31:0] chunk;
      logic [31:0] delim_to;
      logic [31:0] pre_to;
      logic [31:0] ant_delay;
      logic [31:0] pwr;
      logic [31:0] fp_corr;
      logic [31:0] rd;
      logic [7:0]  sym_div;
      logic [31:0] to_cnt;      // Symbols since hunt or detect
      logic [31:0] fwt_cnt;     // Symbols of frame wait
      logic [3:0]  duty_ph;     // Duty-cycle phase in symbols
      logic [12:0] acc;
      logic        fast;
      logic        irq;
      uwfr_pkg::uwfr_ctrl_t ctrl;
   } uwfr_regs_t;

   uwfr_regs_t r_ff;
   uwfr_regs_t nxt_r;

   // Register index decode, used by write, status-clear and command paths; reads use a case
   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] idx);
      hit = (a == idx);
   endfunction : hit

   logic sym_tick;
   logic [31:0] ev;
   logic        fail;
   logic        delim_ok;
   logic        listen_now;

   // One-symbol enable pulse from the clock divider
   assign sym_tick = (r_ff.sym_div == uwfr_pkg::SYM_CYC);

   // Next-state logic
   always_comb
   begin
      nxt_r = r_ff;
      ev = uwfr_pkg::RST_ZERO;
      nxt_r.ctrl.filt_valid = 1'b0;
      nxt_r.sym_div = sym_tick ? 8'h00 : r_ff.sym_div + 8'h01;
      // Delimiter must match length and, if selected, the host code
      delim_ok = radio.delim_hit &&
         (radio.delim_len == (r_ff.cfg[uwfr_pkg::CFG_LONG_DELIM] ?
            uwfr_pkg::DELIM_LONG : uwfr_pkg::DELIM_SHORT)) &&
         (!r_ff.cfg[uwfr_pkg::CFG_USER_DELIM] ||
          radio.delim_code == r_ff.user_delim);
      // Duty cycle: listen for on-symbols out of a 16-symbol period
      listen_now = (r_ff.duty[3:0] == 4'h0) ||
                   (r_ff.duty_ph < r_ff.duty[3:0]);
      if (sym_tick)
      begin
         nxt_r.to_cnt = r_ff.to_cnt + uwfr_pkg::ONE32;
         nxt_r.duty_ph = r_ff.duty_ph + uwfr_pkg::ONE4;
         if (r_ff.st != uwfr_pkg::ST_IDLE)
            nxt_r.fwt_cnt = r_ff.fwt_cnt + uwfr_pkg::ONE32;
      end
      unique case (r_ff.st)
         uwfr_pkg::ST_IDLE:
         begin
            nxt_r.to_cnt = uwfr_pkg::RST_ZERO;
            nxt_r.fwt_cnt = uwfr_pkg::RST_ZERO;
            if (bus.wr && hit(bus.addr, uwfr_pkg::IDX_CONTROL) &&
                bus.wdata[uwfr_pkg::CTL_RX_ENABLE])
               nxt_r.st = uwfr_pkg::ST_HUNT;
         end
         uwfr_pkg::ST_HUNT:
         begin
            // Correlator hits only count while the front end listens
            if (radio.pre_hit && listen_now)
            begin
               nxt_r.st = uwfr_pkg::ST_ACCUM;
               nxt_r.to_cnt = uwfr_pkg::RST_ZERO;
               nxt_r.acc = 13'h0000;
               ev[uwfr_pkg::EV_PRE_DET] = 1'b1;
            end
            else if (r_ff.pre_to != uwfr_pkg::RST_ZERO &&
                     r_ff.to_cnt >= r_ff.pre_to)
               ev[uwfr_pkg::EV_PRE_TO] = 1'b1;
         end
         uwfr_pkg::ST_ACCUM:
         begin
            // Early stop when saturated, hunting goes on
            if (radio.acc_grow && r_ff.acc < uwfr_pkg::ACC_FULL)
               nxt_r.acc = r_ff.acc + uwfr_pkg::ONE13;
            if (delim_ok)
            begin
               nxt_r.st = uwfr_pkg::ST_HDR;
               nxt_r.fast = 1'b0;
               ev[uwfr_pkg::EV_DELIM_DET] = 1'b1;
               nxt_r.tstamp = radio.coarse_ts - r_ff.ant_delay +
                              r_ff.fp_corr;
            end
            else if (r_ff.delim_to != uwfr_pkg::RST_ZERO &&
                     r_ff.to_cnt >= r_ff.delim_to)
               ev[uwfr_pkg::EV_DELIM_TO] = 1'b1;
         end
         uwfr_pkg::ST_HDR:
         begin
            if (radio.hdr_done && !radio.hdr_ok)
               ev[uwfr_pkg::EV_HDR_ERR] = 1'b1;
            else if (radio.hdr_done)
            begin
               nxt_r.st = uwfr_pkg::ST_DATA;
               nxt_r.fast = radio.hdr_fast;
            end
         end
         uwfr_pkg::ST_DATA:
         begin
            if (radio.oct_valid && r_ff.cfg[uwfr_pkg::CFG_FILTER_EN])
            begin
               nxt_r.ctrl.filt_valid = 1'b1;
               nxt_r.ctrl.filt_oct = radio.oct;
            end
            if (radio.rs_fail)
               ev[uwfr_pkg::EV_RS_ERR] = 1'b1;
            else if (radio.frame_end && radio.crc_ok)
            begin
               ev[uwfr_pkg::EV_FRAME_READY] = 1'b1;
               ev[uwfr_pkg::EV_CHECK_GOOD] = 1'b1;
            end
            else if (radio.frame_end)
               ev[uwfr_pkg::EV_FRAME_READY] = 1'b1;
         end
         default:
            nxt_r.st = uwfr_pkg::ST_IDLE;
      endcase
      // Frame wait timeout only when enabled
      if (r_ff.st != uwfr_pkg::ST_IDLE &&
          r_ff.cfg[uwfr_pkg::CFG_FWT_EN] &&
          r_ff.fwt_cnt >= r_ff.fwt_period)
         ev[uwfr_pkg::EV_FWT] = 1'b1;
      fail = ev[uwfr_pkg::EV_PRE_TO] | ev[uwfr_pkg::EV_DELIM_TO] |
             ev[uwfr_pkg::EV_HDR_ERR] | ev[uwfr_pkg::EV_RS_ERR] |
             ev[uwfr_pkg::EV_FWT];
      // Failure idles, or re-hunts with auto re-enable
      if (fail || ev[uwfr_pkg::EV_FRAME_READY])
      begin
         nxt_r.st = r_ff.cfg[uwfr_pkg::CFG_AUTO_REEN] ?
                    uwfr_pkg::ST_HUNT : uwfr_pkg::ST_IDLE;
         nxt_r.to_cnt = uwfr_pkg::RST_ZERO;
         nxt_r.fwt_cnt = uwfr_pkg::RST_ZERO;
      end
      // Host turn-off and receiver-only reset both force idle
      if ((bus.wr && hit(bus.addr, uwfr_pkg::IDX_CONTROL) &&
           bus.wdata[uwfr_pkg::CTL_RX_OFF]) ||
          (bus.wr && hit(bus.addr, uwfr_pkg::IDX_PWR_CLK) &&
           bus.wdata[uwfr_pkg::PWR_RX_RESET]))
         nxt_r.st = uwfr_pkg::ST_IDLE;
      // Register writes
      if (bus.wr)
      begin
         if (hit(bus.addr, uwfr_pkg::IDX_SYS_CFG))    nxt_r.cfg = bus.wdata;
         if (hit(bus.addr, uwfr_pkg::IDX_FWT_PERIOD))
            nxt_r.fwt_period = bus.wdata;
         if (hit(bus.addr, uwfr_pkg::IDX_DUTY_CFG))   nxt_r.duty = bus.wdata;
         if (hit(bus.addr, uwfr_pkg::IDX_USER_DELIM))
            nxt_r.user_delim = bus.wdata;
         if (hit(bus.addr, uwfr_pkg::IDX_CHUNK_SIZE)) nxt_r.chunk = bus.wdata;
         if (hit(bus.addr, uwfr_pkg::IDX_DELIM_TO))
            nxt_r.delim_to = bus.wdata;
         if (hit(bus.addr, uwfr_pkg::IDX_PRE_TO))     nxt_r.pre_to = bus.wdata;
         if (hit(bus.addr, uwfr_pkg::IDX_ANT_DELAY))
            nxt_r.ant_delay = bus.wdata;
         if (hit(bus.addr, uwfr_pkg::IDX_FP_CORR))
            nxt_r.fp_corr = bus.wdata;
         if (hit(bus.addr, uwfr_pkg::IDX_EVT_MASK))   nxt_r.mask = bus.wdata;
         if (hit(bus.addr, uwfr_pkg::IDX_PWR_CLK))
            nxt_r.pwr = bus.wdata &
                        ~(uwfr_pkg::ONE32 << uwfr_pkg::PWR_RX_RESET);
      end
      // Write-one-to-clear; a same-cycle event wins over the clear
      nxt_r.status = (r_ff.status &
         ~((bus.wr && hit(bus.addr, uwfr_pkg::IDX_EVT_STATUS)) ?
           bus.wdata : uwfr_pkg::RST_ZERO)) | ev;
      nxt_r.irq = |(nxt_r.status & nxt_r.mask);
      // Read data one cycle after the strobe, zero when unmapped
      nxt_r.rd = uwfr_pkg::RD_NONE;
      if (bus.rd)
      begin
         unique case (bus.addr)
            uwfr_pkg::IDX_SYS_CFG:    nxt_r.rd = r_ff.cfg;
            uwfr_pkg::IDX_FWT_PERIOD: nxt_r.rd = r_ff.fwt_period;
            uwfr_pkg::IDX_EVT_STATUS: nxt_r.rd = r_ff.status;
            uwfr_pkg::IDX_RX_TSTAMP:  nxt_r.rd = r_ff.tstamp;
            uwfr_pkg::IDX_DUTY_CFG:   nxt_r.rd = r_ff.duty;
            uwfr_pkg::IDX_USER_DELIM: nxt_r.rd = r_ff.user_delim;
            uwfr_pkg::IDX_CHUNK_SIZE: nxt_r.rd = r_ff.chunk;
            uwfr_pkg::IDX_DELIM_TO:   nxt_r.rd = r_ff.delim_to;
            uwfr_pkg::IDX_PRE_TO:     nxt_r.rd = r_ff.pre_to;
            uwfr_pkg::IDX_ANT_DELAY:  nxt_r.rd = r_ff.ant_delay;
            uwfr_pkg::IDX_PWR_CLK:    nxt_r.rd = r_ff.pwr;
            uwfr_pkg::IDX_EVT_MASK:   nxt_r.rd = r_ff.mask;
            uwfr_pkg::IDX_FP_CORR:    nxt_r.rd = r_ff.fp_corr;
            default:                  nxt_r.rd = uwfr_pkg::RD_NONE;
         endcase
      end
      // Radio controls follow the next state
      nxt_r.ctrl.listen = (nxt_r.st == uwfr_pkg::ST_HUNT) ? listen_now :
                          (nxt_r.st != uwfr_pkg::ST_IDLE);
      nxt_r.ctrl.bpm_mode = (nxt_r.st == uwfr_pkg::ST_HDR) ||
                            (nxt_r.st == uwfr_pkg::ST_DATA);
      nxt_r.ctrl.fast_rate = (nxt_r.st == uwfr_pkg::ST_DATA) && nxt_r.fast;
      nxt_r.ctrl.long_delim = r_ff.cfg[uwfr_pkg::CFG_LONG_DELIM];
      nxt_r.ctrl.chunk = r_ff.chunk[6:0];
      nxt_r.ctrl.accumulate = (nxt_r.st == uwfr_pkg::ST_ACCUM) &&
                              (nxt_r.acc < uwfr_pkg::ACC_FULL);
   end

   // State register
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r_ff <= '0;
         r_ff.st <= uwfr_pkg::ST_IDLE;
         r_ff.delim_to <= uwfr_pkg::RST_DELIM_TO;
         r_ff.chunk <= uwfr_pkg::RST_CHUNK;
         r_ff.ctrl.chunk <= uwfr_pkg::DELIM_SHORT;
      end
      else
         r_ff <= nxt_r;
   end

   assign rd_data = r_ff.rd;
   assign ctrl = r_ff.ctrl;
   assign irq = r_ff.irq;

   // Delimiter accepted while accumulating preamble
   sequence seq_delim_taken;
      r_ff.st == uwfr_pkg::ST_ACCUM && delim_ok;
   endsequence

   // Header decoded with bad parity
   sequence seq_hdr_bad;
      r_ff.st == uwfr_pkg::ST_HDR && radio.hdr_done && !radio.hdr_ok;
   endsequence

   // Assertions; a header may follow the delimiter at once, so no slack
   AST_PRE_TO_IDLE: assert property (
      (r_ff.st == uwfr_pkg::ST_HUNT && r_ff.pre_to != uwfr_pkg::RST_ZERO &&
       r_ff.to_cnt >= r_ff.pre_to && !radio.pre_hit &&
       !r_ff.cfg[uwfr_pkg::CFG_AUTO_REEN] && !bus.wr) |=>
      r_ff.status[uwfr_pkg::EV_PRE_TO] && r_ff.st == uwfr_pkg::ST_IDLE)
      else $error("preamble timeout not handled");
   AST_DELIM_BPM: assert property (
      seq_delim_taken ##0 (!bus.wr && !r_ff.cfg[uwfr_pkg::CFG_FWT_EN]) |=>
      ctrl.bpm_mode)
      else $error("no BPM after delimiter");
   AST_SUCCESS: assert property (
      (r_ff.st == uwfr_pkg::ST_DATA && radio.frame_end && radio.crc_ok &&
       !radio.rs_fail) |=> r_ff.status[uwfr_pkg::EV_FRAME_READY] &&
       r_ff.status[uwfr_pkg::EV_CHECK_GOOD])
      else $error("success flags missing");
   AST_STICKY: assert property (
      (r_ff.status[uwfr_pkg::EV_HDR_ERR] && !bus.wr) |=>
      r_ff.status[uwfr_pkg::EV_HDR_ERR])
      else $error("flag lost without clear");
   AST_HDR_ERR: assert property (
      seq_hdr_bad |=> r_ff.status[uwfr_pkg::EV_HDR_ERR] &&
      r_ff.st != uwfr_pkg::ST_DATA)
      else $error("header error not flagged");
   AST_FWT_OFF: assert property (
      (!r_ff.cfg[uwfr_pkg::CFG_FWT_EN] &&
       !$past(r_ff.cfg[uwfr_pkg::CFG_FWT_EN]) &&
       !r_ff.status[uwfr_pkg::EV_FWT]) |=> !r_ff.status[uwfr_pkg::EV_FWT])
      else $error("frame wait fired while disabled");
   AST_IRQ: assert property (
      irq == |(r_ff.status & r_ff.mask))
      else $error("interrupt mismatch");
   AST_STAMP: assert property (
      seq_delim_taken |=> r_ff.tstamp == $past(radio.coarse_ts) -
      $past(r_ff.ant_delay) + $past(r_ff.fp_corr))
      else $error("timestamp wrong");
   AST_FAST: assert property (
      ctrl.fast_rate |-> r_ff.st == uwfr_pkg::ST_DATA)
      else $error("fast rate outside data");

endmodule : uwfr_sequencer

// ---- tb/uwfr_tx_model.sv ----
// Remote transmitter model that plays frames onto the radio indications
`timescale 1ns/1ps
module uwfr_tx_model (
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   input  wire uwfr_pkg::uwfr_ctrl_t ctrl,
   input  wire logic                 go,
   input  wire logic [2:0]           kind,
   input  wire logic [6:0]           dlen,
   input  wire logic [31:0]          dcode,
   input  wire logic [31:0]          ts,
   input  wire logic [7:0]           oct,
   output uwfr_pkg::uwfr_radio_t     radio,
   output logic                      busy
);
   logic [31:0]           cnt_ff = 32'h0000_0000;
   uwfr_pkg::uwfr_radio_t r;

   // Value fields keep moving between pulses so stale data never matches
   function automatic uwfr_pkg::uwfr_radio_t idle_val(input logic [31:0] c);
      uwfr_pkg::uwfr_radio_t v;
      v = '0;
      v.coarse_ts = c;
      v.delim_code = ~c;
      v.oct = c[7:0];
      return v;
   endfunction : idle_val

   // One pulse, then two quiet cycles
   task automatic send(input uwfr_pkg::uwfr_radio_t v);
      radio <= v;
      @(posedge ref_clk);
      radio <= idle_val(cnt_ff);
      repeat (2) @(posedge ref_clk);
   endtask : send

   initial
   begin
      radio = idle_val(32'h0000_0000);
      busy = 1'b0;
   end

   // Pattern counter
   always @(posedge ref_clk) cnt_ff <= cnt_ff + 32'h0000_0001;

   // Frame player; kind 3 sends preamble only, 1 a bad header, 2 a bad octet
   always @(posedge ref_clk)
   begin
      if (go && rst_n)
      begin
         busy <= 1'b1;
         // Preamble is only heard while the front end listens
         for (int i = 0; i < 64 && !ctrl.listen; i++) @(posedge ref_clk);
         r = idle_val(cnt_ff);
         r.pre_hit = 1'b1;
         send(r);
         r = idle_val(cnt_ff);
         r.acc_grow = 1'b1;
         send(r);
         if (kind != 3'd3)
         begin
            r = idle_val(cnt_ff);
            r.delim_hit = 1'b1;
            r.delim_len = dlen;
            r.delim_code = dcode;
            r.coarse_ts = ts;
            send(r);
            r = idle_val(cnt_ff);
            r.hdr_done = 1'b1;
            r.hdr_ok = (kind != 3'd1);
            r.hdr_fast = 1'b1;
            send(r);
            if (kind != 3'd1)
            begin
               r = idle_val(cnt_ff);
               r.oct_valid = 1'b1;
               r.oct = oct;
               r.rs_fail = (kind == 3'd2);
               send(r);
               r = idle_val(cnt_ff);
               r.frame_end = (kind != 3'd2);
               r.crc_ok = (kind != 3'd4);
               send(r);
            end
         end
         busy <= 1'b0;
      end
   end
endmodule : uwfr_tx_model

// ---- tb/uwfr_frame_receive_sequencer_test.sv ----
// Self-checking bench of the receive sequencer with a transmitter model
`timescale 1ns/1ps
module uwfr_frame_receive_sequencer_test;
   logic                  ref_clk = 1'b0;
   logic                  rst_n = 1'b0;
   uwfr_pkg::uwfr_bus_t   bus = '0;
   logic [31:0]           rd_data;
   uwfr_pkg::uwfr_radio_t radio;
   uwfr_pkg::uwfr_ctrl_t  ctrl;
   logic                  irq, busy, seen_bpm, seen_fast, seen_acc;
   logic                  go = 1'b0;
   logic [2:0]            kind = 3'd0;
   logic [6:0]            dlen = 7'h08;
   logic [31:0]           dcode = '0, ts = '0, antd, corr, uc, got;
   logic [31:0]           seed = 32'hec89_820e;
   logic [7:0]            oct = 8'h00, seen_oct;
   logic [2:0]            ks [4] = '{3'd0, 3'd1, 3'd2, 3'd4};
   int                    n_mismatch = 0, tests_run = 0, n_on;

   always #4 ref_clk = ~ref_clk;

   uwfr_sequencer i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus),
      .rd_data(rd_data), .radio(radio), .ctrl(ctrl), .irq(irq));
   uwfr_tx_model i_tx (.ref_clk(ref_clk), .rst_n(rst_n), .ctrl(ctrl),
      .go(go), .kind(kind), .dlen(dlen), .dcode(dcode), .ts(ts), .oct(oct),
      .radio(radio), .busy(busy));

   // Record what the radio side was told during a frame
   always @(posedge ref_clk)
   begin
      if (ctrl.filt_valid) seen_oct <= ctrl.filt_oct;
      if (ctrl.bpm_mode) seen_bpm <= 1'b1;
      if (ctrl.accumulate) seen_acc <= 1'b1;
      if (ctrl.fast_rate && ctrl.bpm_mode) seen_fast <= 1'b1;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Status after a run; 5 refused delimiter, 6 silence, 7 frame wait
   function automatic logic [31:0] exp_st(input logic [2:0] k);
      logic [31:0] e;
      e = 32'h0000_0000;
      if (k == 3'd6) e[uwfr_pkg::EV_PRE_TO] = 1'b1;
      if (k == 3'd7) e[uwfr_pkg::EV_FWT] = 1'b1;
      if (k >= 3'd6) return e;
      e[uwfr_pkg::EV_PRE_DET] = 1'b1;
      if (k == 3'd3) e[uwfr_pkg::EV_DELIM_TO] = 1'b1;
      if (k == 3'd3 || k == 3'd5) return e;
      e[uwfr_pkg::EV_DELIM_DET] = 1'b1;
      e[uwfr_pkg::EV_HDR_ERR] = (k == 3'd1);
      e[uwfr_pkg::EV_RS_ERR] = (k == 3'd2);
      e[uwfr_pkg::EV_FRAME_READY] = (k == 3'd0 || k == 3'd4);
      e[uwfr_pkg::EV_CHECK_GOOD] = (k == 3'd0);
      return e;
   endfunction : exp_st

   task automatic chk32(input logic [31:0] a, input logic [31:0] e);
      tests_run++;
      if (a !== e)
      begin
         n_mismatch++;
         $display("BAD %0t word %h expected %h", $time, a, e);
      end
   endtask : chk32

   task automatic chk1(input logic a, input logic e);
      tests_run++;
      if (a !== e)
      begin
         n_mismatch++;
         $display("BAD %0t flag %b expected %b", $time, a, e);
      end
   endtask : chk1

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge ref_clk);
      bus.wr <= 1'b0;
      @(posedge ref_clk);
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge ref_clk);
      bus.rd <= 1'b0;
      #1 got = rd_data;
      @(posedge ref_clk);
   endtask : rd

   task automatic run(input logic [2:0] k, input logic [6:0] l,
                      input logic [31:0] c);
      wr(uwfr_pkg::IDX_CONTROL, uwfr_pkg::ONE32 << uwfr_pkg::CTL_RX_ENABLE);
      dlen <= l;
      dcode <= c;
      kind <= (k == 3'd5) ? 3'd0 : k;
      ts <= rnd();
      oct <= 8'(rnd());
      seen_bpm <= 1'b0;
      seen_fast <= 1'b0;
      seen_acc <= 1'b0;
      go <= (k < 3'd6);
      @(posedge ref_clk);
      go <= 1'b0;
      @(posedge ref_clk);
      for (int i = 0; i < 200 && busy; i++) @(posedge ref_clk);
      @(negedge ref_clk);
      chk1(busy, 1'b0);
      if (k == 3'd3) chk1(irq, 1'b0);
      for (int i = 0; i < 600 && !irq; i++) @(posedge ref_clk);
      @(negedge ref_clk);
      chk1(ctrl.listen, k == 3'd5);
      chk1(irq, 1'b1);
      @(posedge ref_clk);
      rd(uwfr_pkg::IDX_EVT_STATUS);
      chk32(got, exp_st(k));
      if (k == 3'd0)
      begin
         rd(uwfr_pkg::IDX_RX_TSTAMP);
         chk32(got, ts - antd + corr);
         chk1(seen_bpm, 1'b1);
         chk1(seen_fast, 1'b1);
         chk1(seen_acc, 1'b1);
         chk32({24'h00_0000, seen_oct}, {24'h00_0000, oct});
      end
      if (k == 3'd5)
         wr(uwfr_pkg::IDX_CONTROL, uwfr_pkg::ONE32 << uwfr_pkg::CTL_RX_OFF);
      if (k == 3'd1 || k == 3'd2 || k == 3'd7)
         wr(uwfr_pkg::IDX_PWR_CLK,
            uwfr_pkg::ONE32 << uwfr_pkg::PWR_RX_RESET);
      wr(uwfr_pkg::IDX_EVT_STATUS, 32'hffff_ffff);
      rd(uwfr_pkg::IDX_EVT_STATUS);
      chk32(got, uwfr_pkg::RST_ZERO);
   endtask : run

   task automatic test_done();
      if (n_mismatch == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done

   // Main sequence: reset values, frames in both delimiter modes, timeouts
   initial
   begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rd(uwfr_pkg::IDX_CHUNK_SIZE);
      chk32(got, uwfr_pkg::RST_CHUNK);
      rd(uwfr_pkg::IDX_DELIM_TO);
      chk32(got, 32'h0000_1041);
      rd(8'h3f);
      chk32(got, uwfr_pkg::RD_NONE);
      wr(uwfr_pkg::IDX_CHUNK_SIZE, 32'h0000_0040);
      @(negedge ref_clk);
      chk32({25'h000_0000, ctrl.chunk}, 32'h0000_0040);
      @(posedge ref_clk);
      wr(uwfr_pkg::IDX_CHUNK_SIZE, uwfr_pkg::RST_CHUNK);
      antd = rnd() & 32'h0000_ffff;
      corr = rnd() & 32'h0000_ffff;
      uc = rnd();
      wr(uwfr_pkg::IDX_ANT_DELAY, antd);
      wr(uwfr_pkg::IDX_FP_CORR, corr);
      wr(uwfr_pkg::IDX_USER_DELIM, uc);
      wr(uwfr_pkg::IDX_EVT_MASK, 32'hffff_ffff);
      for (int m = 0; m < 2; m++)
      begin
         wr(uwfr_pkg::IDX_SYS_CFG, (32'(m) << uwfr_pkg::CFG_LONG_DELIM) |
            (32'(m) << uwfr_pkg::CFG_USER_DELIM) | uwfr_pkg::ONE32);
         @(negedge ref_clk);
         chk1(ctrl.long_delim, m == 1);
         @(posedge ref_clk);
         run(3'd5, uwfr_pkg::DELIM_LONG, m ? ~uc : rnd());
         for (int j = 0; j < 4; j++)
            run(ks[j], m ? uwfr_pkg::DELIM_LONG : uwfr_pkg::DELIM_SHORT,
                m ? uc : rnd());
      end
      wr(uwfr_pkg::IDX_EVT_MASK, (uwfr_pkg::ONE32 << uwfr_pkg::EV_PRE_TO) |
         (uwfr_pkg::ONE32 << uwfr_pkg::EV_DELIM_TO) |
         (uwfr_pkg::ONE32 << uwfr_pkg::EV_FWT));
      // One listening symbol in sixteen while hunting, over one period
      wr(uwfr_pkg::IDX_DUTY_CFG, 32'h0000_0001);
      wr(uwfr_pkg::IDX_CONTROL, uwfr_pkg::ONE32 << uwfr_pkg::CTL_RX_ENABLE);
      n_on = 0;
      repeat (16 * (int'(uwfr_pkg::SYM_CYC) + 1))
      begin
         @(negedge ref_clk);
         n_on += int'(ctrl.listen);
      end
      chk32(32'(n_on), 32'(uwfr_pkg::SYM_CYC) + uwfr_pkg::ONE32);
      @(posedge ref_clk);
      wr(uwfr_pkg::IDX_CONTROL, uwfr_pkg::ONE32 << uwfr_pkg::CTL_RX_OFF);
      wr(uwfr_pkg::IDX_DUTY_CFG, uwfr_pkg::RST_ZERO);
      // Frame wait of one symbol with no transmission at all
      wr(uwfr_pkg::IDX_FWT_PERIOD, uwfr_pkg::ONE32);
      wr(uwfr_pkg::IDX_SYS_CFG, uwfr_pkg::ONE32 << uwfr_pkg::CFG_FWT_EN);
      run(3'd7, uwfr_pkg::DELIM_LONG, uc);
      wr(uwfr_pkg::IDX_SYS_CFG, uwfr_pkg::RST_ZERO);
      wr(uwfr_pkg::IDX_PRE_TO, 32'h0000_0002);
      run(3'd6, uwfr_pkg::DELIM_LONG, uc);
      wr(uwfr_pkg::IDX_PRE_TO, uwfr_pkg::RST_ZERO);
      wr(uwfr_pkg::IDX_DELIM_TO, 32'h0000_0002);
      run(3'd3, uwfr_pkg::DELIM_LONG, uc);
      test_done();
   end

   // Watchdog well beyond the expected run length
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      test_done();
   end
endmodule : uwfr_frame_receive_sequencer_test
